// file: ocp_char_pixel.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Purpose: per-pixel attribute and colour processing for the display
// Assumes: clk is the pixel clock; font bits arrive per matrix line
// Notes: border and screen options over apb; row and char attrs are ports
`include "ocp_consts.svh"
module ocp_char_pixel (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // display state
    input  wire logic        display_on,
    input  wire logic        field_odd,
    input  wire logic        in_row,
    input  wire logic        row_end,
    // row attributes
    input  wire logic [2:0]  row_mode,
    input  wire logic        row_big,
    input  wire logic        row_flash_on,
    input  wire logic        row_round_en,
    input  wire logic        row_fringe_en,
    input  wire logic        row_dbl_x,
    input  wire logic        row_dbl_y,
    input  wire logic        interlaced,
    // character word, up to 24 bits, and its pixel position
    input  wire logic [23:0] char_word,
    input  wire logic        char_start,
    input  wire logic [4:0]  char_line,
    input  wire logic [4:0]  char_col,
    input  wire logic [4:0]  char_width,
    input  wire logic        ctrl_code,
    input  wire logic        ctrl_bg_change,
    input  wire logic        ctrl_italic_set,
    input  wire logic        ctrl_italic_clr,
    input  wire logic        char_flash,
    // font and computed layers for this pixel
    input  wire logic        font_dot,
    input  wire logic        round_dot,
    input  wire logic        fringe_dot,
    input  wire logic        uline_dot,
    input  wire logic [11:0] fg_entry,
    input  wire logic [11:0] bg_entry,
    // output pixel
    output logic      [8:0]  pix_rgb,
    output logic      [2:0]  pix_trans,
    output logic             pix_valid,
    output logic      [8:0]  font_line
);
    logic       rst_s1_reg;
    logic       rst_s2_reg;
    logic [8:0] border_rgb_reg;
    logic [2:0] border_trans_reg;
    logic       all_bg_border_reg;
    logic [8:0] uline_rgb_reg;
    logic [2:0] uline_trans_reg;
    logic       italic_reg;
    logic       prev_italic_char_reg;
    logic       prev_bg_code_reg;
    logic [8:0] carry_bg_reg;
    logic [2:0] carry_trans_reg;
    logic [8:0] pix_rgb_next;
    logic [2:0] pix_trans_next;
    ocp_pkg::ocp_colour_type  pick_col;
    ocp_pkg::ocp_layer_type   pick_layer;
    ocp_pkg::ocp_layer_type   last_layer_reg;
    ocp_pix_if                pif ();

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // apb decode: zero-wait, unmapped addresses answer error
    wire apb_acc     = psel && penable;
    wire apb_wr      = apb_acc && pwrite;
    wire hit_border0 = paddr == `OCP_ADDR_BORDER0;
    wire hit_border1 = paddr == `OCP_ADDR_BORDER1;
    wire hit_screen  = paddr == `OCP_ADDR_SCREEN;
    wire hit_row     = paddr == `OCP_ADDR_ROW;
    wire hit_uline   = paddr == `OCP_ADDR_ULINE;
    wire hit_status  = paddr == `OCP_ADDR_STATUS;
    wire hit_any     = hit_border0 | hit_border1 | hit_screen | hit_row
                     | hit_uline | hit_status;
    assign pready  = 1'b1;
    assign pslverr = apb_acc && !hit_any;

    // border colour split over two registers: rgb low bits, then high + trans
    always_ff @(posedge clk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            border_rgb_reg    <= `OCP_BORDER_RST;
            border_trans_reg  <= `OCP_TRANS_RST;
            all_bg_border_reg <= 1'b0;
            uline_rgb_reg     <= 9'h000;
            uline_trans_reg   <= `OCP_TRANS_RST;
        end else if (apb_wr) begin
            if (hit_border0) border_rgb_reg[5:0] <= pwdata[5:0];
            if (hit_border1) begin
                border_rgb_reg[8:6] <= pwdata[2:0];
                border_trans_reg    <= pwdata[6:4];
            end
            if (hit_screen) all_bg_border_reg <= pwdata[0];
            if (hit_uline) begin
                uline_rgb_reg   <= pwdata[8:0];
                uline_trans_reg <= pwdata[14:12];
            end
        end
    end

    // read mux; row register mirrors live row attribute inputs
    wire [31:0] rd_status = {24'h000000, last_layer_reg, italic_reg, display_on};
    wire [31:0] rd_row    = {24'h000000, row_dbl_y, row_dbl_x, row_fringe_en,
                             row_round_en, row_flash_on, row_big, row_mode[1:0]};
    assign prdata = hit_border0 ? {26'h0000000, border_rgb_reg[5:0]} :
                    hit_border1 ? {25'h0000000, border_trans_reg, 1'b0,
                                   border_rgb_reg[8:6]} :
                    hit_screen  ? {31'h00000000, all_bg_border_reg} :
                    hit_row     ? rd_row :
                    hit_uline   ? {17'h00000, uline_trans_reg, 3'h0, uline_rgb_reg} :
                    hit_status  ? rd_status : 32'h00000000;

    // character fields by row mode
    wire mode_ser = row_mode == ocp_pkg::OCP_MODE_SERIAL;
    wire mode_ext = row_mode == ocp_pkg::OCP_MODE_EXT;
    wire [7:0] code     = char_word[7:0];
    wire       ext_dblh = mode_ext && char_word[16];
    wire       ext_dblw = mode_ext && char_word[17];
    wire       ext_fl   = mode_ext && char_word[18];
    wire       ext_shad = mode_ext && char_word[19];
    wire       ext_frn  = mode_ext && char_word[20];
    wire       ext_fgx  = mode_ext && char_word[21];
    wire       ext_bgx  = mode_ext && char_word[22];
    wire       is_test  = code == `OCP_TEST_CODE;

    // effective size per row and per character
    wire eff_dbl_y = row_dbl_y | ext_dblh;
    wire eff_dbl_x = row_dbl_x | ext_dblw;

    // italic state: set and clear by control codes, serial rows only
    always_ff @(posedge clk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            italic_reg <= 1'b0;
        end else if (row_end || !mode_ser) begin
            italic_reg <= 1'b0;
        end else if (char_start && ctrl_italic_set) begin
            italic_reg <= 1'b1;
        end else if (char_start && ctrl_italic_clr) begin
            italic_reg <= 1'b0;
        end
    end

    // slant: stepped shift, max at top line, zero at bottom, in groups
    logic [2:0] slant;
    always_comb begin
        if (row_big) begin
            if (char_line >= 5'd21) slant = 3'd0;
            else slant = `OCP_SLANT_MAX_BIG - 3'(char_line / `OCP_SLANT_GROUP_BIG);
        end else begin
            if (char_line >= 5'd10) slant = 3'd0;
            else slant = `OCP_SLANT_MAX_SMALL - 3'(char_line >> 1);
        end
    end

    // control codes and test code are never slanted
    wire        slant_on  = italic_reg && mode_ser && !ctrl_code && !is_test;
    wire [5:0]  col_shift = slant_on ? ({1'b0, char_col} - {3'h0, slant})
                                     : {1'b0, char_col};
    wire        shift_neg = col_shift[5];
    // truncation of the last italic character at its unslanted end
    wire        past_end  = slant_on && row_end && char_col >= char_width;
    wire        half_zone = char_col < {1'b0, char_width[4:1]};

    // font line addressing per matrix format and field
    logic [4:0] mline;
    always_comb begin
        if (!row_big) begin
            mline = eff_dbl_y ? {1'b0, char_line[4:1]} : char_line;
        end else if (interlaced && !eff_dbl_y) begin
            mline = {char_line[3:0], field_odd};
        end else begin
            mline = eff_dbl_y ? {1'b0, char_line[4:1]} : char_line;
        end
    end
    assign font_line = {row_big, ext_fgx, ext_bgx, ext_shad, 5'(mline)};

    // remember prior character kind for half-width extension
    always_ff @(posedge clk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            prev_italic_char_reg <= 1'b0;
            prev_bg_code_reg     <= 1'b0;
            carry_bg_reg         <= 9'h000;
            carry_trans_reg      <= 3'h0;
        end else if (char_start) begin
            prev_italic_char_reg <= slant_on;
            // a test code never carries its colour forward
            prev_bg_code_reg     <= italic_reg && ctrl_bg_change && !is_test;
            carry_bg_reg         <= bg_entry[8:0];
            carry_trans_reg      <= bg_entry[11:9];
        end
    end

    // italic or bg-code background extends halfway, ignoring mix bit
    wire extend_bg = half_zone && italic_reg && !row_end &&
                     ((prev_italic_char_reg && (ctrl_bg_change || is_test))
                      || (prev_bg_code_reg && ctrl_bg_change));

    // flash: character flash needs the row-wide enable
    wire flash_hide = row_flash_on && (char_flash || ext_fl);

    // rounding disabled for big matrix at single size
    wire round_ok = row_round_en && !(row_big && !eff_dbl_x && !eff_dbl_y);
    wire fringe_ok = row_fringe_en || ext_frn;

    wire dot_ok   = !shift_neg && !past_end && !ctrl_code && !flash_hide;
    wire fore_pix = dot_ok && (font_dot || (round_ok && round_dot));

    // candidate colours to the picker
    wire [8:0] bg_rgb   = extend_bg ? carry_bg_reg : bg_entry[8:0];
    wire [2:0] bg_trans = extend_bg ? carry_trans_reg : bg_entry[11:9];
    assign pif.is_test = is_test;
    assign pif.in_char = in_row && display_on && !past_end;
    assign pif.fore    = fore_pix;
    assign pif.fringe  = fringe_ok && fringe_dot && !ctrl_code;
    assign pif.uline   = uline_dot && !ctrl_code && !flash_hide;
    assign pif.fg      = '{rgb: fg_entry[8:0], trans: fg_entry[11:9]};
    assign pif.bg      = all_bg_border_reg ?
                         '{rgb: border_rgb_reg, trans: border_trans_reg} :
                         '{rgb: bg_rgb, trans: bg_trans};
    assign pif.ul      = '{rgb: uline_rgb_reg, trans: uline_trans_reg};
    assign pif.bd      = '{rgb: border_rgb_reg, trans: border_trans_reg};

    ocp_colour_pick u_pick (
        .p     (pif),
        .col   (pick_col),
        .layer (pick_layer)
    );

    // display off drives black, fully transparent
    assign pix_rgb_next   = display_on ? pick_col.rgb : 9'h000;
    assign pix_trans_next = display_on ? pick_col.trans : 3'h0;

    // output registers
    always_ff @(posedge clk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            pix_rgb        <= 9'h000;
            pix_trans      <= 3'h0;
            pix_valid      <= 1'b0;
            last_layer_reg <= ocp_pkg::OCP_LAY_BORDER;
        end else begin
            pix_rgb        <= pix_rgb_next;
            pix_trans      <= pix_trans_next;
            pix_valid      <= display_on;
            last_layer_reg <= pick_layer;
        end
    end
endmodule // ocp_char_pixel

// file: ocp_char_pixel_sva.sv
`timescale 1ns/1ps
// Purpose: checker for pixel colour selection and register side effects
// Assumes: shadow copies of border, underline and screen option from apb writes
// Notes: serial rows left out of the layer checks, italics may move edges there
module ocp_char_pixel_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        display_on,
    input wire logic        in_row,
    input wire logic [2:0]  row_mode,
    input wire logic        row_big,
    input wire logic        row_flash_on,
    input wire logic        row_round_en,
    input wire logic        row_fringe_en,
    input wire logic        row_dbl_x,
    input wire logic        row_dbl_y,
    input wire logic [23:0] char_word,
    input wire logic        char_flash,
    input wire logic        font_dot,
    input wire logic        round_dot,
    input wire logic        fringe_dot,
    input wire logic        uline_dot,
    input wire logic [11:0] fg_entry,
    input wire logic [11:0] bg_entry,
    input wire logic [8:0]  pix_rgb,
    input wire logic [2:0]  pix_trans,
    input wire logic [8:0]  font_line
);
    logic [8:0]  bd_rgb_reg;
    logic [2:0]  bd_tr_reg;
    logic [11:0] ul_reg;
    logic        scr_reg;
    // decode of pixel causes; round is dropped for the big matrix at 1x,1y
    wire         wr_hit  = psel & penable & pwrite & pready;
    wire         code_ok = display_on & in_row & (char_word[7:0] != 8'h00) & (row_mode != 3'h1);
    wire         rnd_ok  = round_dot & row_round_en & ~(row_big & ~row_dbl_x & ~row_dbl_y);
    wire         frg_ok  = fringe_dot & (row_fringe_en | ((row_mode == 3'h4) & char_word[20]));
    wire         hide    = row_flash_on & char_flash;
    wire         none_ok = code_ok & ~uline_dot & ~font_dot & ~rnd_ok & ~frg_ok;
    wire [11:0]  pix     = {pix_trans, pix_rgb};
    wire [11:0]  bd      = {bd_tr_reg, bd_rgb_reg};
    // shadow registers follow completed writes only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {bd_tr_reg, bd_rgb_reg, ul_reg, scr_reg} <= {3'h7, 9'h000, 12'hE00, 1'b0};
        end else if (wr_hit) begin
            case (paddr)
                12'h000: bd_rgb_reg[5:0] <= pwdata[5:0];
                12'h004: {bd_tr_reg, bd_rgb_reg[8:6]} <= {pwdata[6:4], pwdata[2:0]};
                12'h008: scr_reg <= pwdata[0];
                12'h010: ul_reg <= {pwdata[14:12], pwdata[8:0]};
                default: scr_reg <= scr_reg;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_off; !display_on |=> pix == 12'h000; endproperty
    a_off: assert property (p_off) else $error("pixel not dark with display off");
    property p_border; display_on & ~in_row |=> pix == $past(bd); endproperty
    a_border: assert property (p_border) else $error("border colour wrong");
    property p_test;
        display_on & in_row & (char_word[7:0] == 8'h00) & (row_mode != 3'h1) |=> pix == $past(bd);
    endproperty
    a_test: assert property (p_test) else $error("test code not in border colour");
    property p_ul; code_ok & uline_dot & ~hide |=> pix == $past(ul_reg); endproperty
    a_ul: assert property (p_ul) else $error("underline colour wrong");
    property p_fg; code_ok & ~uline_dot & ~hide & (font_dot | rnd_ok) |=> pix == $past(fg_entry);
    endproperty
    a_fg: assert property (p_fg) else $error("foreground colour wrong");
    property p_frg; code_ok & ~uline_dot & ~font_dot & ~rnd_ok & frg_ok |=> pix == 12'hE00;
    endproperty
    a_frg: assert property (p_frg) else $error("fringe not opaque black");
    property p_bg; none_ok & ~scr_reg |=> pix == $past(bg_entry); endproperty
    a_bg: assert property (p_bg) else $error("background colour wrong");
    property p_scr; none_ok & scr_reg |=> pix == $past(bd); endproperty
    a_scr: assert property (p_scr) else $error("background not shown as border");
    property p_mat;
        font_line[8:5] == {row_big, (row_mode == 3'h4) & char_word[21],
                           (row_mode == 3'h4) & char_word[22], (row_mode == 3'h4) & char_word[19]};
    endproperty
    a_mat: assert property (p_mat) else $error("matrix select not passed to font");
    property p_err; psel & penable & (paddr > 12'h014) |-> pslverr & pready & (prdata == 32'h0);
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule // ocp_char_pixel_sva
bind ocp_char_pixel ocp_char_pixel_sva chk_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .display_on, .in_row, .row_mode, .row_big,
    .row_flash_on, .row_round_en, .row_fringe_en, .row_dbl_x, .row_dbl_y, .char_word,
    .char_flash, .font_dot, .round_dot, .fringe_dot, .uline_dot, .fg_entry, .bg_entry,
    .pix_rgb, .pix_trans, .font_line);

// file: ocp_colour_pick.sv
`timescale 1ns/1ps
// Purpose: chooses the output colour of one pixel by layer priority
// Assumes: inputs valid in the same cycle
// Notes: combinational; the top registers the result
`include "ocp_consts.svh"
module ocp_colour_pick (
    ocp_pix_if.dst                    p,
    output ocp_pkg::ocp_colour_type   col,
    output ocp_pkg::ocp_layer_type    layer
);
    // priority: border (test code or outside character), underline, foreground, fringe, background
    always_comb begin
        if (p.is_test || !p.in_char) begin
            col   = p.bd;
            layer = p.is_test ? ocp_pkg::OCP_LAY_TEST : ocp_pkg::OCP_LAY_BORDER;
        end else if (p.uline) begin
            col   = p.ul;
            layer = ocp_pkg::OCP_LAY_ULINE;
        end else if (p.fore) begin
            col   = p.fg;
            layer = ocp_pkg::OCP_LAY_FORE;
        end else if (p.fringe) begin
            // fringe ignores the palette entirely
            col   = '{rgb: `OCP_BLACK, trans: `OCP_TRANS_OPAQUE};
            layer = ocp_pkg::OCP_LAY_FRINGE;
        end else begin
            col   = p.bg;
            layer = ocp_pkg::OCP_LAY_BACK;
        end
    end
endmodule // ocp_colour_pick

// file: ocp_consts.svh
// Purpose: constants for the character pixel attribute block
// Assumes: apb byte addresses, 32-bit data words
// Notes: translucency 0 is fully transparent, 7 fully opaque
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH
`define OCP_ADDR_BORDER0    12'h000
`define OCP_ADDR_BORDER1    12'h004
`define OCP_ADDR_SCREEN     12'h008
`define OCP_ADDR_ROW        12'h00C
`define OCP_ADDR_ULINE      12'h010
`define OCP_ADDR_STATUS     12'h014
`define OCP_BORDER_RST      9'h000
`define OCP_TRANS_RST       3'h7
`define OCP_TRANS_OPAQUE    3'h7
`define OCP_BLACK           9'h000
`define OCP_TEST_CODE       8'h00
`define OCP_LINES_BIG       5'd26
`define OCP_LINES_SMALL     5'd13
`define OCP_SLANT_GROUP_BIG 3'd4
`define OCP_SLANT_MAX_BIG   3'd5
`define OCP_SLANT_MAX_SMALL 3'd5
`endif

// file: ocp_pix_if.sv
`timescale 1ns/1ps
// Purpose: carries one pixel's layer flags and candidate colours
// Assumes: single clock domain
// Notes: producer is the top, consumer the colour picker
interface ocp_pix_if;
    logic                  is_test;
    logic                  fore;
    logic                  fringe;
    logic                  uline;
    logic                  in_char;
    ocp_pkg::ocp_colour_type fg;
    ocp_pkg::ocp_colour_type bg;
    ocp_pkg::ocp_colour_type ul;
    ocp_pkg::ocp_colour_type bd;
    modport src (output is_test, fore, fringe, uline, in_char, fg, bg, ul, bd);
    modport dst (input is_test, fore, fringe, uline, in_char, fg, bg, ul, bd);
endinterface

// file: ocp_pkg.sv
// Purpose: types for the character pixel attribute block
// Assumes: included constants header
// Notes: one-hot codes for layer and row mode
package ocp_pkg;
    typedef enum logic [2:0] {
        OCP_MODE_SERIAL = 3'b001,
        OCP_MODE_BASIC  = 3'b010,
        OCP_MODE_EXT    = 3'b100
    } ocp_mode_type;
    typedef enum logic [5:0] {
        OCP_LAY_BORDER = 6'b000001,
        OCP_LAY_BACK   = 6'b000010,
        OCP_LAY_FRINGE = 6'b000100,
        OCP_LAY_FORE   = 6'b001000,
        OCP_LAY_ULINE  = 6'b010000,
        OCP_LAY_TEST   = 6'b100000
    } ocp_layer_type;
    typedef struct packed {
        logic [8:0] rgb;
        logic [2:0] trans;
    } ocp_colour_type;
endpackage

// file: ocp_tv_model.sv
`timescale 1ns/1ps
// Purpose: video processor side, latches rgb and blanking level each pixel clock
// Assumes: one clock; the receiver has no handshake back to the block
// Notes: the bench reads the latched copy, one clock behind the block outputs
module ocp_tv_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [8:0] pix_rgb,
    input  wire logic [2:0] pix_trans,
    input  wire logic       pix_valid,
    output logic      [8:0] seen_rgb,
    output logic      [2:0] seen_trans,
    output logic            seen_valid
);
    // the receiver samples every clock, it cannot ask for a repeat
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {seen_rgb, seen_trans, seen_valid} <= 13'h0000;
        end else begin
            {seen_rgb, seen_trans, seen_valid} <= {pix_rgb, pix_trans, pix_valid};
        end
    end
endmodule // ocp_tv_model

// file: testbench.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for pixel layer selection and border registers
// Assumes: zero-wait apb, pixel registered one clock after its inputs
// Notes: italic state judged through status reads; slanted pixels are not judged
module testbench;
    localparam logic [13:0] ON = 14'h0001, ROW = 14'h0002, FNT = 14'h0004, RND = 14'h0008,
        FRG = 14'h0010, UL = 14'h0020, REN = 14'h0040, FEN = 14'h0080, BIG = 14'h0100,
        DX = 14'h0200, DY = 14'h0400, FLO = 14'h0800, CFL = 14'h1000, ITL = 14'h2000;
    localparam logic [2:0] MS = 3'h1, MB = 3'h2, ME = 3'h4;
    localparam logic [2:0] S_FG = 3'h0, S_BG = 3'h1, S_BD = 3'h2, S_UL = 3'h3, S_BK = 3'h4;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, re, field_odd;
    logic        char_start, pix_valid, seen_valid;
    logic [4:0]  cc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] fl;
    logic [2:0]  row_mode, pix_trans, seen_trans, bd_t;
    logic [23:0] char_word;
    logic [11:0] fg_entry, bg_entry;
    logic [4:0]  char_line, char_col, char_width;
    logic [8:0]  pix_rgb, font_line, seen_rgb;
    int          err_count, num_checks;
    ocp_char_pixel dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .display_on(fl[0]), .field_odd(field_odd), .in_row(fl[1]),
        .row_end(cc[4]), .row_mode(row_mode), .row_big(fl[8]), .row_flash_on(fl[11]),
        .row_round_en(fl[6]), .row_fringe_en(fl[7]), .row_dbl_x(fl[9]), .row_dbl_y(fl[10]),
        .interlaced(fl[13]), .char_word(char_word), .char_start(char_start),
        .char_line(char_line), .char_col(char_col), .char_width(char_width), .ctrl_code(cc[0]),
        .ctrl_bg_change(cc[1]), .ctrl_italic_set(cc[2]), .ctrl_italic_clr(cc[3]),
        .char_flash(fl[12]), .font_dot(fl[2]), .round_dot(fl[3]), .fringe_dot(fl[4]),
        .uline_dot(fl[5]), .fg_entry(fg_entry), .bg_entry(bg_entry), .pix_rgb(pix_rgb),
        .pix_trans(pix_trans), .pix_valid(pix_valid), .font_line(font_line));
    ocp_tv_model tv_u (.clk(clk), .rst_b(rst_b), .pix_rgb(pix_rgb), .pix_trans(pix_trans),
        .pix_valid(pix_valid), .seen_rgb(seen_rgb), .seen_trans(seen_trans),
        .seen_valid(seen_valid));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb master: hold the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_count++;
            give_verdict();
        end
        rd = prdata;
        re = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // one character: start pulse, then a held pixel judged at the video side
    task automatic lay(input logic [13:0] f, input logic [2:0] m, input logic [23:0] w,
                       input logic [2:0] src);
        logic [11:0] fv, bv, e;
        fv = 12'hA5C + {4'h0, w[7:0]};
        bv = 12'h6E1 - {4'h0, w[7:0]};
        case (src)
            S_FG: e = fv;
            S_BG: e = bv;
            S_BD: e = {bd_t, 9'h1A5};
            S_UL: e = 12'hAF3;
            S_BK: e = 12'hE00;
            default: e = 12'h000;
        endcase
        @(posedge clk);
        {fl, row_mode, char_word, fg_entry, bg_entry} <= {f, m, w, fv, bv};
        {char_start, char_col, char_width} <= {1'b1, 5'h00, f[8] ? 5'h12 : 5'h09};
        char_line <= (char_line == 5'h0C) ? 5'h00 : char_line + 5'h01;
        field_odd <= ~field_odd;
        @(posedge clk);
        {char_start, char_col} <= {1'b0, 5'h01};
        repeat (2) @(posedge clk);
        #1;
        chk({20'h0, seen_trans, seen_rgb}, {20'h0, e});
        chk({31'h0, seen_valid}, {31'h0, f[0]});
    endtask
    // italic set by a control code in a serial row, cleared at row end
    task automatic t_italic();
        @(posedge clk);
        cc <= 5'h05;
        lay(ON | ROW | FNT, MS, 24'h60, S_BG);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd & 32'h3, 32'h3);
        @(posedge clk);
        cc <= 5'h10;
        apb(1'b0, 12'h014, 32'h0);
        chk(rd & 32'h3, 32'h1);
        @(posedge clk);
        cc <= 5'h00;
        lay(ON | ROW | FNT, MB, 24'h61, S_FG);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h0000_0002);
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0070);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0000_7000);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk({31'h0, re}, 32'h1);
        apb(1'b1, 12'h000, 32'h0000_0025);
        apb(1'b1, 12'h004, 32'h0000_0036);
        apb(1'b1, 12'h010, 32'h0000_50F3);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0036);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0000_50F3);
    endtask
    task automatic t_border();
        for (int t = 0; t < 8; t++) begin
            bd_t = t[2:0];
            apb(1'b1, 12'h004, {25'h0, bd_t, 4'h6});
            lay(ON, MB, 24'h41, S_BD);
        end
        bd_t = 3'h3;
        apb(1'b1, 12'h004, 32'h0000_0036);
    endtask
    task automatic t_layers();
        lay(ON | ROW | FNT | FRG | UL | FEN, MB, 24'h41, S_UL);
        lay(ON | ROW | FNT | FRG | FEN, MB, 24'h42, S_FG);
        lay(ON | ROW | RND | FRG | REN | FEN, MB, 24'h43, S_FG);
        lay(ON | ROW | FRG | FEN | ITL, MB, 24'h44, S_BK);
        lay(ON | ROW, ME, 24'h45, S_BG);
        lay(ON | ROW | RND | REN | BIG, MB, 24'h46, S_BG);
        lay(ON | ROW | RND | REN | BIG | DX, ME, 24'h47, S_FG);
        lay(ON | ROW | RND | REN | BIG | DY | ITL, MS, 24'h48, S_FG);
        lay(ON | ROW | FRG, ME, 24'h10_0049, S_BK);
        lay(ON | ROW | FRG, ME, 24'h00_004A, S_BG);
        lay(ON | ROW | FRG | FEN | BIG | DX | DY, MB, 24'h4B, S_BK);
        lay(ON | ROW | FNT | UL, MB, 24'h00, S_BD);
        lay(ON | ROW | FNT | CFL, MS, 24'h4C, S_FG);
        lay(ON | ROW | FNT | FLO | CFL, MS, 24'h4D, S_BG);
        lay(ROW | FNT, MB, 24'h4E, 3'h5);
    endtask
    task automatic t_screen();
        apb(1'b1, 12'h008, 32'h0000_0001);
        lay(ON | ROW, MB, 24'h50, S_BD);
        lay(ON | ROW | FNT, MB, 24'h51, S_FG);
        apb(1'b1, 12'h008, 32'h0000_0000);
        lay(ON | ROW, MB, 24'h52, S_BG);
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // pixel clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // watchdog, well beyond the roughly 190 clocks the tests take
    initial begin
        #50000;
        err_count++;
        give_verdict();
    end
    // reset, then the scenarios in order
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, fl, row_mode, cc} = '0;
        {char_word, fg_entry, bg_entry, char_line, char_col, char_width} = '0;
        {field_odd, char_start, err_count, num_checks, bd_t} = {2'b00, 64'h0, 3'h3};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_border();
        t_layers();
        t_screen();
        t_italic();
        give_verdict();
    end
endmodule // testbench
